/* File: aec_env5.sv */
`default_nettype none
module aec_env5
    import aec_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Counter values and directions
    input wire logic [31:0] cmd_pos_value,
    input wire logic [31:0] mech_pos_value,
    input wire logic [15:0] deflection_value,
    input wire logic [31:0] general_value,
    input wire logic [31:0] positioning_value,
    input wire logic [31:0] speed_value,
    input wire logic count_up,
    input wire logic count_down,
    // Other comparators and ramp events, same clock
    input wire logic [3:0] cmp_match_1to4,
    input wire logic accel_start,
    input wire logic accel_end,
    input wire logic decel_start,
    input wire logic decel_end,
    input wire logic [3:0] sync_from_axes,
    // Pins
    input wire logic latch_input,
    input wire logic origin_input,
    // Sticky flags and cause registers
    input wire logic set_flag_a,
    input wire logic set_flag_b,
    input wire logic clear_flag_a_cmd,
    input wire logic clear_flag_b_cmd,
    input wire logic main_status_read,
    input wire logic cause_regs_read,
    input wire logic cause_regs_write,
    output logic sticky_flag_a,
    output logic sticky_flag_b,
    output logic cause_clear,
    // Actions
    output logic stop_now,
    output logic stop_decel,
    output logic reload_speed,
    output logic [2:0] idle_pulse_count,
    output logic latch_strobe,
    output logic [3:0] counter_clear,
    output logic sync_out,
    output logic sync_start,
    output logic irq
);
    logic [31:0] env_cfg;
    logic [31:0] cmp5_value;
    logic [AEC_NST-1:0] stat;
    logic [AEC_NST-1:0] mask;
    logic [31:0] latch_c3;
    logic sw_latch;
    logic [1:0] ltc_sync, org_sync;
    logic ltc_q, org_q;
    logic [31:0] src_value;
    logic [31:0] defl_abs;
    logic match5;
    logic hw_trigger;
    logic latch_now;
    logic sync_evt;
    aec_wstate_type wstate;
    logic [7:0] waddr;
    logic aw_done, w_done;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_fire;
    logic [31:0] bytemask;

    wire [2:0] cmp5_source_sel = env_cfg[AEC_SRC_LSB +: 3];
    wire [2:0] cmp5_method_sel = env_cfg[AEC_METH_LSB +: 3];
    wire [1:0] cmp5_action_sel = env_cfg[AEC_ACT_LSB +: 2];
    wire [1:0] latch_trigger_sel = env_cfg[AEC_LTRIG_LSB +: 2];
    wire latch_speed_instead = env_cfg[AEC_LSPEED_BIT];
    wire hw_latch_disable = env_cfg[AEC_HWOFF_BIT];
    wire [3:0] sync_out_event_sel = env_cfg[AEC_SYO_LSB +: 4];
    wire [1:0] sync_in_axis_sel = env_cfg[AEC_SYI_LSB +: 2];
    wire main_status_keep_on_read = env_cfg[AEC_MSKEEP_BIT];
    wire cause_regs_keep_on_read = env_cfg[AEC_CAKEEP_BIT];
    wire status_read_clear = main_status_read && !main_status_keep_on_read;
    wire [3:0] clear_on_latch = env_cfg[AEC_CLR_LSB +: 4];

    // Pin inputs cross two flops before anything looks at them.
    always_ff @(posedge clk) begin
        if (srst) begin
            ltc_sync <= 2'h0;
            org_sync <= 2'h0;
            ltc_q <= 1'b0;
            org_q <= 1'b0;
        end else begin
            ltc_sync <= {ltc_sync[0], latch_input};
            org_sync <= {org_sync[0], origin_input};
            ltc_q <= ltc_sync[1];
            org_q <= org_sync[1];
        end
    end

    // Magnitude saturates so that -32768 still fits the positive range.
    always_comb begin
        if (deflection_value[15]) begin
            defl_abs = 32'(16'(-deflection_value));
        end else begin
            defl_abs = 32'(deflection_value);
        end
        if (defl_abs > 32'(AEC_DEFL_MAX)) begin
            defl_abs = 32'(AEC_DEFL_MAX);
        end
    end

    always_comb begin
        unique case (cmp5_source_sel)
            3'h0: src_value = cmd_pos_value;
            3'h1: src_value = mech_pos_value;
            3'h2: src_value = defl_abs;
            3'h3: src_value = general_value;
            3'h4: src_value = positioning_value;
            3'h5: src_value = speed_value;
            default: src_value = 32'h0000_0000;
        endcase
    end

    aec_cmp5 u_cmp5 (
        .clk(clk),
        .srst(srst),
        .method(cmp5_method_sel),
        .compare_value(cmp5_value),
        .source_value(src_value),
        .count_up(count_up),
        .count_down(count_down),
        .match_pulse(match5)
    );

    always_comb begin
        unique case (latch_trigger_sel)
            2'h0: hw_trigger = ltc_sync[1] && !ltc_q;
            2'h1: hw_trigger = org_sync[1] && !org_q;
            2'h2: hw_trigger = cmp_match_1to4[3];
            default: hw_trigger = match5;
        endcase
    end
    assign latch_now = sw_latch || (hw_trigger && !hw_latch_disable);

    always_comb begin
        unique case (sync_out_event_sel)
            4'h1, 4'h2, 4'h3, 4'h4:
                sync_evt = cmp_match_1to4[sync_out_event_sel[1:0] - 2'h1];
            4'h5: sync_evt = match5;
            4'h8: sync_evt = accel_start;
            4'h9: sync_evt = accel_end;
            4'hA: sync_evt = decel_start;
            4'hB: sync_evt = decel_end;
            default: sync_evt = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            stop_now <= 1'b0;
            stop_decel <= 1'b0;
            reload_speed <= 1'b0;
            latch_strobe <= 1'b0;
            counter_clear <= 4'h0;
            sync_out <= 1'b0;
            sync_start <= 1'b0;
            idle_pulse_count <= 3'h0;
        end else begin
            stop_now <= match5 && cmp5_action_sel == 2'h1;
            stop_decel <= match5 && cmp5_action_sel == 2'h2;
            reload_speed <= match5 && cmp5_action_sel == 2'h3;
            latch_strobe <= latch_now;
            counter_clear <= latch_now ? clear_on_latch : 4'h0;
            sync_out <= sync_evt;
            sync_start <= sync_from_axes[sync_in_axis_sel];
            idle_pulse_count <= env_cfg[AEC_IDLE_LSB +: 3];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            latch_c3 <= 32'h0000_0000;
        end else if (latch_now) begin
            latch_c3 <= latch_speed_instead ? speed_value
                : {{16{deflection_value[15]}}, deflection_value};
        end
    end

    // Sticky flags: set wins over any clear in the same cycle.
    always_ff @(posedge clk) begin
        if (srst) begin
            sticky_flag_a <= 1'b0;
            sticky_flag_b <= 1'b0;
        end else begin
            if (set_flag_a) begin
                sticky_flag_a <= 1'b1;
            end else if (clear_flag_a_cmd || status_read_clear) begin
                sticky_flag_a <= 1'b0;
            end
            if (set_flag_b) begin
                sticky_flag_b <= 1'b1;
            end else if (clear_flag_b_cmd || status_read_clear) begin
                sticky_flag_b <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cause_clear <= 1'b0;
        end else begin
            cause_clear <= cause_regs_keep_on_read ? cause_regs_write
                : cause_regs_read;
        end
    end

    // AXI4-Lite write path.
    assign wr_fire = wstate == AEC_W_DATA;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            bytemask[8*i +: 8] = {8{wstrb_q[i]}};
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wstate <= AEC_W_IDLE;
            aw_done <= 1'b0;
            w_done <= 1'b0;
            waddr <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            unique case (wstate)
                AEC_W_IDLE: begin
                    s_axi_awready <= !aw_done && !s_axi_awready;
                    s_axi_wready <= !w_done && !s_axi_wready;
                    if (s_axi_awvalid && s_axi_awready) begin
                        waddr <= s_axi_awaddr;
                        aw_done <= 1'b1;
                        s_axi_awready <= 1'b0;
                    end
                    if (s_axi_wvalid && s_axi_wready) begin
                        wdata_q <= s_axi_wdata;
                        wstrb_q <= s_axi_wstrb;
                        w_done <= 1'b1;
                        s_axi_wready <= 1'b0;
                    end
                    if ((aw_done || (s_axi_awvalid && s_axi_awready))
                        && (w_done || (s_axi_wvalid && s_axi_wready))) begin
                        wstate <= AEC_W_DATA;
                        s_axi_awready <= 1'b0;
                        s_axi_wready <= 1'b0;
                    end
                end
                AEC_W_DATA: begin
                    aw_done <= 1'b0;
                    w_done <= 1'b0;
                    s_axi_bvalid <= 1'b1;
                    s_axi_bresp <= (waddr == AEC_CFG_ADDR
                        || waddr == AEC_CMP5_ADDR || waddr == AEC_STAT_ADDR
                        || waddr == AEC_MASK_ADDR || waddr == AEC_SWL_ADDR)
                        ? 2'h0 : 2'h2;
                    wstate <= AEC_W_RESP;
                end
                AEC_W_RESP: begin
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        wstate <= AEC_W_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            env_cfg <= AEC_CFG_RESET;
            cmp5_value <= AEC_CMP5_RESET;
            mask <= AEC_MASK_RESET;
            sw_latch <= 1'b0;
        end else begin
            sw_latch <= wr_fire && waddr == AEC_SWL_ADDR && wstrb_q[0]
                && wdata_q[0];
            if (wr_fire && waddr == AEC_CFG_ADDR) begin
                env_cfg <= (env_cfg & ~(bytemask & AEC_CFG_WMASK))
                    | (wdata_q & bytemask & AEC_CFG_WMASK);
            end
            if (wr_fire && waddr == AEC_CMP5_ADDR) begin
                cmp5_value <= (cmp5_value & ~bytemask) | (wdata_q & bytemask);
            end
            if (wr_fire && waddr == AEC_MASK_ADDR && wstrb_q[0]) begin
                mask <= wdata_q[AEC_NST-1:0];
            end
        end
    end

    // Status is write-one-to-clear; a new event in the same cycle wins.
    always_ff @(posedge clk) begin
        if (srst) begin
            stat <= '0;
            irq <= 1'b0;
        end else begin
            stat <= (stat & ~((wr_fire && waddr == AEC_STAT_ADDR
                && wstrb_q[0]) ? wdata_q[AEC_NST-1:0] : '0))
                | {cmp5_method_sel > 3'h5 || cmp5_method_sel == 3'h0,
                   set_flag_b, set_flag_a, sync_evt, latch_now, match5};
            irq <= |(stat & mask);
        end
    end

    // AXI4-Lite read path, one read at a time.
    always_ff @(posedge clk) begin
        if (srst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            unique case (s_axi_araddr)
                AEC_CFG_ADDR: s_axi_rdata <= env_cfg;
                AEC_CMP5_ADDR: s_axi_rdata <= cmp5_value;
                AEC_STAT_ADDR: s_axi_rdata <= 32'(stat);
                AEC_MASK_ADDR: s_axi_rdata <= 32'(mask);
                AEC_LCH_ADDR: s_axi_rdata <= latch_c3;
                AEC_SWL_ADDR: s_axi_rdata <= 32'h0000_0000;
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else begin
            s_axi_arready <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: aec_pkg.sv */
`default_nettype none
package aec_pkg;
    // Register map, byte addresses on the AXI4-Lite slave.
    localparam logic [7:0] AEC_CFG_ADDR = 8'h00;
    localparam logic [7:0] AEC_CMP5_ADDR = 8'h04;
    localparam logic [7:0] AEC_STAT_ADDR = 8'h08;
    localparam logic [7:0] AEC_MASK_ADDR = 8'h0C;
    localparam logic [7:0] AEC_LCH_ADDR = 8'h10;
    localparam logic [7:0] AEC_SWL_ADDR = 8'h14;

    // Fields of environment_five_config.
    localparam int AEC_SRC_LSB = 0;
    localparam int AEC_METH_LSB = 3;
    localparam int AEC_ACT_LSB = 6;
    localparam int AEC_IDLE_LSB = 8;
    localparam int AEC_LTRIG_LSB = 12;
    localparam int AEC_LSPEED_BIT = 14;
    localparam int AEC_HWOFF_BIT = 15;
    localparam int AEC_SYO_LSB = 16;
    localparam int AEC_SYI_LSB = 20;
    localparam int AEC_MSKEEP_BIT = 22;
    localparam int AEC_CAKEEP_BIT = 23;
    localparam int AEC_CLR_LSB = 24;
    localparam logic [31:0] AEC_CFG_WMASK = 32'h0FFF_F7FF;
    localparam logic [31:0] AEC_CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] AEC_CMP5_RESET = 32'h0000_0000;
    localparam logic [5:0] AEC_MASK_RESET = 6'h00;

    // Status bit positions.
    localparam int AEC_ST_MATCH = 0;
    localparam int AEC_ST_LATCH = 1;
    localparam int AEC_ST_SYNC = 2;
    localparam int AEC_ST_FLAGA = 3;
    localparam int AEC_ST_FLAGB = 4;
    localparam int AEC_ST_BADM = 5;
    localparam int AEC_NST = 6;

    localparam logic [14:0] AEC_DEFL_MAX = 15'h7FFF;

    typedef enum logic [2:0] {
        AEC_M_ANY = 3'h1,
        AEC_M_UP = 3'h2,
        AEC_M_DOWN = 3'h3,
        AEC_M_GT = 3'h4,
        AEC_M_LT = 3'h5
    } aec_method_type;

    typedef enum logic [2:0] {
        AEC_W_IDLE = 3'b001,
        AEC_W_DATA = 3'b010,
        AEC_W_RESP = 3'b100
    } aec_wstate_type;
endpackage
`default_nettype wire

/* File: aec_cmp5.sv */
`default_nettype none
module aec_cmp5
    import aec_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Setup
    input wire logic [2:0] method,
    input wire logic [31:0] compare_value,
    // Selected source
    input wire logic [31:0] source_value,
    input wire logic count_up,
    input wire logic count_down,
    // Result
    output logic match_pulse
);
    logic cond;
    logic cond_q;
    logic eq;

    assign eq = compare_value == source_value;

    // Compares are signed, like the counters they watch.
    always_comb begin
        unique case (method)
            AEC_M_ANY: cond = eq;
            AEC_M_UP: cond = eq && count_up;
            AEC_M_DOWN: cond = eq && count_down;
            AEC_M_GT: cond = $signed(compare_value) > $signed(source_value);
            AEC_M_LT: cond = $signed(compare_value) < $signed(source_value);
            default: cond = 1'b0;
        endcase
    end

    // Only the rising edge of the condition counts, so a held match is
    // reported once.
    always_ff @(posedge clk) begin
        if (srst) begin
            cond_q <= 1'b0;
            match_pulse <= 1'b0;
        end else begin
            cond_q <= cond;
            match_pulse <= cond && !cond_q;
        end
    end
endmodule
`default_nettype wire

/* File: aec_env5_assertions.sv */
`default_nettype none
module aec_env5_chk
    import aec_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    // Event inputs
    input wire logic [3:0] sync_from_axes,
    input wire logic set_flag_a,
    input wire logic clear_flag_b_cmd,
    input wire logic main_status_read,
    input wire logic cause_regs_read,
    input wire logic cause_regs_write,
    // Watched outputs
    input wire logic sticky_flag_a,
    input wire logic sticky_flag_b,
    input wire logic cause_clear,
    input wire logic stop_now,
    input wire logic stop_decel,
    input wire logic reload_speed,
    input wire logic [2:0] idle_pulse_count,
    input wire logic latch_strobe,
    input wire logic [3:0] counter_clear,
    input wire logic sync_out,
    input wire logic sync_start
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // The idle count may only move shortly after a write beat.
    logic [3:0] wcnt;
    always_ff @(posedge clk) begin
        if (srst || (s_axi_awvalid && s_axi_awready)
                || (s_axi_wvalid && s_axi_wready)) begin
            wcnt <= 4'h0;
        end else if (wcnt != 4'hF) begin
            wcnt <= wcnt + 4'h1;
        end
    end

    idle_after_write_a: assert property (
        !$stable(idle_pulse_count) |-> wcnt < 4'h6)
        else $error("idle count moved without a write");
    action_onehot_a: assert property (
        $onehot0({stop_now, stop_decel, reload_speed}))
        else $error("two motion actions at once");
    stop_pulse_a: assert property (stop_now |=> !stop_now)
        else $error("stop pulse longer than one cycle");
    reload_pulse_a: assert property (reload_speed |=> !reload_speed)
        else $error("reload pulse longer than one cycle");
    clear_with_latch_a: assert property (
        |counter_clear |-> latch_strobe)
        else $error("counter clear without latch");
    sticky_set_a: assert property (set_flag_a |=> sticky_flag_a)
        else $error("flag a not set");
    sticky_rise_a: assert property (
        $rose(sticky_flag_a) |-> $past(set_flag_a))
        else $error("flag a rose without set");
    flag_b_clear_a: assert property (
        $fell(sticky_flag_b) |-> $past(clear_flag_b_cmd || main_status_read))
        else $error("flag b fell without cause");
    cause_clear_src_a: assert property (
        cause_clear |-> $past(cause_regs_read || cause_regs_write))
        else $error("cause clear without access");
    sync_start_src_a: assert property (
        sync_start |-> $past(|sync_from_axes))
        else $error("sync start without axis signal");

    cover property (stop_decel);
    cover property ($fell(sticky_flag_a));
    cover property (|counter_clear);
    cover property (sync_out);
endmodule

bind aec_env5 aec_env5_chk aec_env5_chk_inst (
    .clk, .srst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .sync_from_axes, .set_flag_a, .clear_flag_b_cmd,
    .main_status_read, .cause_regs_read, .cause_regs_write,
    .sticky_flag_a, .sticky_flag_b, .cause_clear, .stop_now, .stop_decel,
    .reload_speed, .idle_pulse_count, .latch_strobe, .counter_clear,
    .sync_out, .sync_start
);
`default_nettype wire

/* File: aec_env5_test.sv */
`default_nettype none
module aec_env5_test
    import aec_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [31:0] cmd_pos_value = 32'h0, mech_pos_value = 32'h0;
    logic [31:0] general_value = 32'h0, positioning_value = 32'h0;
    logic [31:0] speed_value = 32'h0;
    logic [15:0] deflection_value = 16'h0;
    logic count_up = 1'b0, count_down = 1'b0;
    logic [21:0] evin = 22'h00_0000;
    wire latch_input = evin[0], origin_input = evin[1];
    wire [3:0] cmp_match_1to4 = evin[5:2];
    wire accel_start = evin[7], accel_end = evin[8];
    wire decel_start = evin[9], decel_end = evin[10];
    wire [3:0] sync_from_axes = evin[14:11];
    wire set_flag_a = evin[15], set_flag_b = evin[16];
    wire clear_flag_a_cmd = evin[17], clear_flag_b_cmd = evin[18];
    wire main_status_read = evin[19], cause_regs_read = evin[20];
    wire cause_regs_write = evin[21];
    logic sticky_flag_a, sticky_flag_b, cause_clear, stop_now, stop_decel;
    logic reload_speed, latch_strobe, sync_out, sync_start, irq;
    logic [2:0] idle_pulse_count;
    logic [3:0] counter_clear;
    wire [6:0] evv = {cause_clear, sync_start, sync_out, latch_strobe,
        reload_speed, stop_decel, stop_now};
    int ev [7] = '{default: 0};
    int b [7];
    int lk [4] = '{0, 1, 5, 6};
    int mt [12][6] = '{'{1, 0, 0, 0, 16, 1}, '{2, 1, 0, 0, 16, 1},
        '{2, 0, 1, 0, 16, 0}, '{3, 0, 1, 0, 16, 1}, '{3, 1, 0, 0, 16, 0},
        '{4, 0, 0, 17, 15, 1}, '{4, 0, 0, 17, 18, 0},
        '{5, 0, 0, 15, 17, 1}, '{5, 0, 0, 15, 14, 0},
        '{0, 0, 0, 0, 16, 0}, '{6, 0, 0, 0, 16, 0}, '{7, 0, 0, 0, 16, 0}};
    logic [3:0] last_clr = 4'h0;
    logic [31:0] c, e;
    int errors = 0;
    int check_count = 0;

    aec_env5 aec_env5_inst (.*);

    always #4 clk = ~clk;

    // Pulses are counted here so that no one-cycle event is missed.
    always @(posedge clk) begin
        for (int i = 0; i < 7; i++) ev[i] <= ev[i] + int'(evv[i] === 1'b1);
        if (latch_strobe === 1'b1) last_clr <= counter_clear;
    end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(string nm, logic [31:0] ex, logic [31:0] g);
        check_count++;
        if (g !== ex) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, ex, g);
        end
    endtask

    task automatic hang();
        errors++;
        $display("[ERR] bus answer expected 1 seen 0");
        close_out();
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask

    function automatic logic [31:0] f(int v, int lsb);
        return 32'(v) << lsb;
    endfunction

    task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er = 2'h0);
        int n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 40);
        if (n >= 40) hang();
        chk("bresp", 32'(er), 32'(s_axi_bresp));
    endtask

    task automatic rd(logic [7:0] a, logic [31:0] ed, logic [1:0] er = 2'h0,
            bit cd = 1);
        int n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 40);
        if (n >= 40) hang();
        chk("rresp", 32'(er), 32'(s_axi_rresp));
        if (cd) chk("rdata", ed, s_axi_rdata);
    endtask

    task automatic set_src(int s, logic [31:0] v);
        cmd_pos_value <= (s == 0) ? v : 32'h0;
        mech_pos_value <= (s == 1) ? v : 32'h0;
        deflection_value <= (s == 2) ? -v[15:0] : 16'h0;
        general_value <= (s == 3) ? v : 32'h0;
        positioning_value <= (s == 4) ? v : 32'h0;
        speed_value <= (s == 5) ? v : 32'h0;
    endtask

    task automatic pulse(int k, int w);
        evin[k] <= 1'b1;
        tick(w);
        evin[k] <= 1'b0;
        tick(3);
    endtask

    // Motion actions are packed as nibbles {reload, decel, stop}.
    task automatic trial(int s, logic [31:0] cf, logic [31:0] base, trig,
            logic [11:0] ex);
        set_src(s, base);
        tick(2);
        wr(AEC_CFG_ADDR, cf);
        tick(4);
        b = ev;
        set_src(s, trig);
        tick(6);
        chk("cmp5 actions", 32'(ex), 32'(ev[0] - b[0])
            | 32'(ev[1] - b[1]) << 4 | 32'(ev[2] - b[2]) << 8);
    endtask

    // Fires events k0..k1 one at a time; bit k marks a single output pulse.
    task automatic sweep(string nm, int idx, k0, k1, logic [31:0] ex);
        logic [31:0] h = 32'h0;
        for (int k = k0; k <= k1; k++) begin
            b = ev;
            if (k == 6) begin
                set_src(0, 32'h10);
                tick(6);
                set_src(0, 32'h0);
            end else begin
                pulse(k, k < 2 ? 4 : 1);
            end
            tick(6);
            if (ev[idx] - b[idx] == 1) h[k] = 1'b1;
            else if (ev[idx] != b[idx]) h[31] = 1'b1;
        end
        chk(nm, ex, h);
    endtask

    task automatic flags(logic [1:0] ex);
        chk("sticky flags", 32'(ex), 32'({sticky_flag_b, sticky_flag_a}));
    endtask

    initial begin
        tick(2);
        srst <= 1'b0;
        tick(1);
        rd(AEC_CFG_ADDR, AEC_CFG_RESET);
        rd(AEC_CMP5_ADDR, AEC_CMP5_RESET);
        rd(AEC_MASK_ADDR, 32'(AEC_MASK_RESET));
        wr(AEC_CFG_ADDR, 32'hFFFF_FFFF);
        rd(AEC_CFG_ADDR, 32'h0FFF_F7FF);
        tick(3);
        chk("idle count", 32'h7, 32'(idle_pulse_count));
        wr(8'h18, 32'h1, 2'h2);
        rd(8'h18, 32'h0, 2'h2, 1'b0);
        wr(AEC_CMP5_ADDR, 32'h10);
        rd(AEC_CMP5_ADDR, 32'h10);
        for (int s = 0; s < 6; s++) begin
            c = f(s, AEC_SRC_LSB) | f(1, AEC_METH_LSB) | f(1, AEC_ACT_LSB);
            trial(s, c, 32'h0, 32'h10, 12'h001);
        end
        for (int i = 0; i < 12; i++) begin
            count_up <= mt[i][1][0];
            count_down <= mt[i][2][0];
            c = f(mt[i][0], AEC_METH_LSB) | f(1, AEC_ACT_LSB);
            trial(0, c, mt[i][3], mt[i][4], 12'(mt[i][5]));
        end
        wr(AEC_MASK_ADDR, 32'h1);
        for (int a = 0; a < 4; a++) begin
            c = f(1, AEC_METH_LSB) | f(a, AEC_ACT_LSB);
            trial(0, c, 32'h0, 32'h10, 12'(a ? 1 << 4 * a - 4 : 0));
        end
        wr(AEC_STAT_ADDR, 32'h3E);
        chk("irq", 32'h1, 32'(irq));
        rd(AEC_STAT_ADDR, 32'h1);
        wr(AEC_STAT_ADDR, 32'h1);
        tick(3);
        chk("irq", 32'h0, 32'(irq));
        wr(AEC_MASK_ADDR, 32'h0);
        trial(0, c, 32'h0, 32'h10, 12'h100);
        rd(AEC_STAT_ADDR, 32'h1);
        chk("irq", 32'h0, 32'(irq));
        set_src(0, 32'h0);
        for (int t = 0; t < 4; t++) begin
            c = f(1, AEC_METH_LSB) | f(t, AEC_LTRIG_LSB) | f(5, AEC_CLR_LSB);
            wr(AEC_CFG_ADDR, c);
            sweep("latch trigger", 3, 0, 6, 32'(1) << lk[t]);
            chk("counter clear", 32'h5, 32'(last_clr));
        end
        wr(AEC_CFG_ADDR, f(1, AEC_HWOFF_BIT));
        sweep("latch blocked", 3, 0, 1, 32'h0);
        b = ev;
        wr(AEC_SWL_ADDR, 32'h1);
        tick(4);
        chk("software latch", 32'h1, 32'(ev[3] - b[3]));
        deflection_value <= 16'h0055;
        speed_value <= 32'h0000_0777;
        wr(AEC_CFG_ADDR, 32'h0);
        wr(AEC_SWL_ADDR, 32'h1);
        rd(AEC_LCH_ADDR, 32'h55);
        wr(AEC_CFG_ADDR, f(1, AEC_LSPEED_BIT));
        wr(AEC_SWL_ADDR, 32'h1);
        rd(AEC_LCH_ADDR, 32'h777);
        set_src(0, 32'h0);
        for (int s = 0; s < 16; s++) begin
            wr(AEC_CFG_ADDR, f(1, AEC_METH_LSB) | f(s, AEC_SYO_LSB));
            e = 32'h0;
            if (s >= 1 && s <= 5) e[s + 1] = 1'b1;
            if (s >= 8 && s <= 11) e[s - 1] = 1'b1;
            sweep("sync out", 4, 2, 10, e);
        end
        for (int s = 0; s < 4; s++) begin
            wr(AEC_CFG_ADDR, f(s, AEC_SYI_LSB));
            sweep("sync start", 5, 11, 14, 32'(1) << (11 + s));
        end
        wr(AEC_CFG_ADDR, 32'h0);
        pulse(15, 1);
        pulse(16, 1);
        flags(2'h3);
        pulse(19, 1);
        flags(2'h0);
        sweep("cause clear", 6, 20, 20, 32'(1) << 20);
        wr(AEC_CFG_ADDR, f(1, AEC_MSKEEP_BIT) | f(1, AEC_CAKEEP_BIT));
        pulse(15, 1);
        pulse(16, 1);
        pulse(19, 1);
        flags(2'h3);
        pulse(17, 1);
        flags(2'h2);
        pulse(18, 1);
        flags(2'h0);
        sweep("cause clear", 6, 20, 21, 32'(1) << 21);
        close_out();
    end
endmodule
`default_nettype wire
